// ### rtl/pcr_lane_cfg.sv
// Purpose: Lane coding-rate configuration registers behind the dynamic
//          reconfiguration port, with the fabric sideband port mapper.
// Assumes: APB3-style slave, one wait state per access; synchronous pins.
// Notes:   Fields are driven to the lane straight from the registers.
//
// Overview of operation
// R1 - Every mode-dependent lane field is rewritten on each coding change.
// R2 - Fields go over the reconfiguration port; the lane accepts them.
// R3 - Coding path one-hot: 0100 selects 8b10b, 0010 selects 64b6xB.
// R4 - Fabric tx and rx bus meaning follows the coding path field.
// R5 - Fabric rx and tx clock selects are 1 in both modes.
// R6 - Coder rx and tx clock source selects are 3 in both modes.
// R7 - FIFO clock selects follow gear width in 8b10b, are 2 in 64b6xB.
// R8 - The four 8b10b clock enables are 1 in 8b10b, 0 in 64b6xB.
// R9 - Ports reserved in a mode are ignored inputs and meaningless outputs.
// R10 - 64b6xB enables set in wide mode; half-rate only for 64-bit fabric.
// R11 - Deserializer and serializer widths: 7 for 8b10b, 6 for 64b6xB.
// R12 - Slip control enable is 1 in 8b10b and 0 in 64b6xB.
// R13 - Slip source is 0 in 8b10b (fabric) and 1 in 64b6xB.
`timescale 1ns/10ps
`include "pcr_defines.svh"
module pcr_lane_cfg
  import pcr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Dynamic reconfiguration port, APB signalling.
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Lane control fields.
  output logic             octet_swap_sel,
  output logic      [1:0]  fifo_path_width,
  output logic      [3:0]  fabric_path_sel,
  output logic      [3:0]  coding_path_onehot_sel,
  output logic      [1:0]  fabric_rx_clock_sel,
  output logic      [1:0]  fabric_tx_clock_sel,
  output logic      [1:0]  coder_rx_clock_sel,
  output logic      [1:0]  coder_tx_clock_sel,
  output logic      [1:0]  rx_fifo_write_clock_sel,
  output logic      [1:0]  tx_fifo_read_clock_sel,
  output logic             rx_fifo_pipe_sel,
  output logic             narrow_code_rx_clock_en,
  output logic             narrow_code_rx_fifo_clock_en,
  output logic             narrow_code_tx_clock_en,
  output logic             narrow_code_tx_fifo_clock_en,
  output logic             wide_code_rx_clock_en,
  output logic             wide_code_rx_half_clock_en,
  output logic             wide_code_tx_clock_en,
  output logic             wide_code_tx_half_clock_en,
  output logic      [2:0]  deser_width_sel,
  output logic      [2:0]  ser_width_sel,
  output logic             cdr_slip_enable,
  output logic             cdr_slip_source,
  output logic             narrow_mode,
  output logic             wide_mode,
  // Fabric sideband, shared between coding paths.
  input  wire logic [7:0]  fab_tx_k,
  input  wire logic [15:0] fab_tx_dispfnc,
  output logic      [7:0]  fab_rx_k,
  output logic      [7:0]  fab_rx_code_viol,
  output logic      [7:0]  fab_rx_disp_err,
  // Coder side.
  output logic      [7:0]  nar_tx_k,
  output logic      [15:0] nar_tx_disp,
  output logic      [3:0]  wide_tx_hdr,
  output logic             wide_tx_sos,
  output logic             wide_tx_elec_idle,
  output logic             wide_tx_bypass,
  input  wire logic [7:0]  nar_rx_k,
  input  wire logic [7:0]  nar_rx_code_viol,
  input  wire logic [7:0]  nar_rx_disp_err,
  input  wire logic        wide_rx_bypass,
  input  wire logic [3:0]  wide_rx_hdr,
  input  wire logic        wide_rx_hdr_val,
  input  wire logic        wide_rx_sos,
  input  wire logic        wide_rx_data_val,
  input  wire logic        wide_status_lock,
  input  wire logic        wide_status_hi_ber
);

  pcr_cfg_state_t cur_ff;
  pcr_cfg_state_t nxt_ff;
  pcr_map_state_t map_out;
  pcr_map_if      mif ();

  logic        access;
  logic        hit;
  logic [31:0] rd_word;
  logic [31:0] status_word;
  logic [3:0]  new_path;

  assign access = psel && penable && (cur_ff.st == PCR_ST_IDLE);

  // A write to the overlay register decodes the path in the same edge
  // that stores it, so the flags never lag the field.
  assign new_path = (access && pwrite && paddr == `PCR_OFS_OVERLAY) ?
                    pwdata[`PCR_CODE_PATH_LSB +: 4] :
                    cur_ff.overlay[`PCR_CODE_PATH_LSB +: 4];

  assign status_word = {30'h0000_0000, cur_ff.wide_mode, cur_ff.narrow_mode};

  always_comb begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      `PCR_OFS_OCTET_GEAR: rd_word = cur_ff.octet_gear;
      `PCR_OFS_OVERLAY:    rd_word = cur_ff.overlay;
      `PCR_OFS_CLK_SRC:    rd_word = cur_ff.clk_src;
      `PCR_OFS_CLK_EN:     rd_word = cur_ff.clk_en;
      `PCR_OFS_SERDES_W:   rd_word = cur_ff.serdes_w;
      `PCR_OFS_CDR_SLIP:   rd_word = cur_ff.cdr_slip;
      `PCR_OFS_STATUS:     rd_word = status_word;
      default:             hit = 1'b0;
    endcase
  end

  always_comb begin
    nxt_ff         = cur_ff;
    nxt_ff.pready  = 1'b0;
    nxt_ff.pslverr = 1'b0;
    case (cur_ff.st)
      PCR_ST_IDLE: begin
        if (access) begin
          nxt_ff.st      = PCR_ST_ACK;
          nxt_ff.pready  = 1'b1;
          nxt_ff.pslverr = !hit || (pwrite && paddr == `PCR_OFS_STATUS);
          nxt_ff.prdata  = pwrite ? 32'h0000_0000 : rd_word;
          if (pwrite) begin // [R2]
            case (paddr)
              `PCR_OFS_OCTET_GEAR:
                nxt_ff.octet_gear = pwdata & `PCR_MASK_OCTET_GEAR;
              `PCR_OFS_OVERLAY:
                nxt_ff.overlay = pwdata & `PCR_MASK_OVERLAY;
              `PCR_OFS_CLK_SRC:
                nxt_ff.clk_src = pwdata & `PCR_MASK_CLK_SRC;
              `PCR_OFS_CLK_EN:
                nxt_ff.clk_en = pwdata & `PCR_MASK_CLK_EN;
              `PCR_OFS_SERDES_W:
                nxt_ff.serdes_w = pwdata & `PCR_MASK_SERDES_W;
              `PCR_OFS_CDR_SLIP:
                nxt_ff.cdr_slip = pwdata & `PCR_MASK_CDR_SLIP;
              default: begin
              end
            endcase
          end
        end
      end
      PCR_ST_ACK: begin
        nxt_ff.st = PCR_ST_IDLE;
      end
      default: begin
        nxt_ff.st = PCR_ST_IDLE;
      end
    endcase
    // Any pattern other than the two legal ones selects no path. [R3]
    nxt_ff.narrow_mode = (new_path == `PCR_PATH_NARROW);
    nxt_ff.wide_mode   = (new_path == `PCR_PATH_WIDE);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff             <= '0;
      cur_ff.st          <= PCR_ST_IDLE;
      cur_ff.octet_gear  <= `PCR_RST_OCTET_GEAR;
      cur_ff.overlay     <= `PCR_RST_OVERLAY;
      cur_ff.clk_src     <= `PCR_RST_CLK_SRC;
      cur_ff.clk_en      <= `PCR_RST_CLK_EN;
      cur_ff.serdes_w    <= `PCR_RST_SERDES_W;
      cur_ff.cdr_slip    <= `PCR_RST_CDR_SLIP;
      cur_ff.narrow_mode <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign mif.narrow_mode = cur_ff.narrow_mode;
  assign mif.wide_mode   = cur_ff.wide_mode;

  pcr_path_map u_map (
    .clock              (clock),
    .rst_n              (rst_n),
    .mif                (mif.map),
    .fab_tx_k           (fab_tx_k),
    .fab_tx_dispfnc     (fab_tx_dispfnc),
    .nar_rx_k           (nar_rx_k),
    .nar_rx_code_viol   (nar_rx_code_viol),
    .nar_rx_disp_err    (nar_rx_disp_err),
    .wide_rx_bypass     (wide_rx_bypass),
    .wide_rx_hdr        (wide_rx_hdr),
    .wide_rx_hdr_val    (wide_rx_hdr_val),
    .wide_rx_sos        (wide_rx_sos),
    .wide_rx_data_val   (wide_rx_data_val),
    .wide_status_lock   (wide_status_lock),
    .wide_status_hi_ber (wide_status_hi_ber),
    .mout               (map_out)
  );

  assign prdata  = cur_ff.prdata;
  assign pready  = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;

  assign octet_swap_sel          = cur_ff.octet_gear[`PCR_SWAP_BIT];
  assign fifo_path_width         = cur_ff.octet_gear[`PCR_GEAR_LSB +: 2];
  assign fabric_path_sel         = cur_ff.overlay[`PCR_FAB_PATH_LSB +: 4];
  assign coding_path_onehot_sel  = cur_ff.overlay[`PCR_CODE_PATH_LSB +: 4];
  assign fabric_rx_clock_sel     = cur_ff.clk_src[`PCR_FAB_RX_LSB +: 2];
  assign fabric_tx_clock_sel     = cur_ff.clk_src[`PCR_FAB_TX_LSB +: 2];
  assign coder_rx_clock_sel      = cur_ff.clk_src[`PCR_CODER_RX_LSB +: 2];
  assign coder_tx_clock_sel      = cur_ff.clk_src[`PCR_CODER_TX_LSB +: 2];
  assign rx_fifo_write_clock_sel = cur_ff.clk_src[`PCR_RXF_WR_LSB +: 2];
  assign tx_fifo_read_clock_sel  = cur_ff.clk_src[`PCR_TXF_RD_LSB +: 2];
  assign rx_fifo_pipe_sel        = cur_ff.clk_src[`PCR_RXF_PIPE_BIT];

  assign narrow_code_rx_clock_en      = cur_ff.clk_en[`PCR_EN_NRX_BIT];
  assign narrow_code_rx_fifo_clock_en = cur_ff.clk_en[`PCR_EN_NRXF_BIT];
  assign narrow_code_tx_clock_en      = cur_ff.clk_en[`PCR_EN_NTX_BIT];
  assign narrow_code_tx_fifo_clock_en = cur_ff.clk_en[`PCR_EN_NTXF_BIT];
  assign wide_code_rx_clock_en        = cur_ff.clk_en[`PCR_EN_WRX_BIT];
  assign wide_code_rx_half_clock_en   = cur_ff.clk_en[`PCR_EN_WRXH_BIT];
  assign wide_code_tx_clock_en        = cur_ff.clk_en[`PCR_EN_WTX_BIT];
  assign wide_code_tx_half_clock_en   = cur_ff.clk_en[`PCR_EN_WTXH_BIT];

  assign deser_width_sel = cur_ff.serdes_w[`PCR_DESER_LSB +: 3];
  assign ser_width_sel   = cur_ff.serdes_w[`PCR_SER_LSB +: 3];
  assign cdr_slip_enable = cur_ff.cdr_slip[`PCR_SLIP_EN_BIT];
  assign cdr_slip_source = cur_ff.cdr_slip[`PCR_SLIP_SRC_BIT];
  assign narrow_mode     = cur_ff.narrow_mode;
  assign wide_mode       = cur_ff.wide_mode;

  assign fab_rx_k          = map_out.fab_rx_k;
  assign fab_rx_code_viol  = map_out.fab_rx_code_viol;
  assign fab_rx_disp_err   = map_out.fab_rx_disp_err;
  assign nar_tx_k          = map_out.nar_tx_k;
  assign nar_tx_disp       = map_out.nar_tx_disp;
  assign wide_tx_hdr       = map_out.wide_tx_hdr;
  assign wide_tx_sos       = map_out.wide_tx_sos;
  assign wide_tx_elec_idle = map_out.wide_tx_elec_idle;
  assign wide_tx_bypass    = map_out.wide_tx_bypass;

endmodule

// ### rtl/pcr_defines.svh
// Purpose: Offsets, field positions, masks and reset values of the lane
//          coding-rate configuration registers.
// Assumes: Byte addresses on an 8-bit register address; word aligned.
// Notes:   Reset values select the narrow (8b10b) coding path.
`ifndef PCR_DEFINES_SVH
`define PCR_DEFINES_SVH

`define PCR_ADDR_W          8
`define PCR_OFS_OCTET_GEAR  8'h00
`define PCR_OFS_OVERLAY     8'h04
`define PCR_OFS_CLK_SRC     8'h08
`define PCR_OFS_CLK_EN      8'h0C
`define PCR_OFS_SERDES_W    8'h10
`define PCR_OFS_CDR_SLIP    8'h14
`define PCR_OFS_STATUS      8'h18

// lane_octet_gear_ctrl fields.
`define PCR_SWAP_BIT        0
`define PCR_GEAR_LSB        1
// lane_interface_overlay_ctrl fields.
`define PCR_FAB_PATH_LSB    0
`define PCR_CODE_PATH_LSB   4
// lane_clock_source_select fields.
`define PCR_FAB_RX_LSB      0
`define PCR_FAB_TX_LSB      2
`define PCR_CODER_RX_LSB    4
`define PCR_CODER_TX_LSB    6
`define PCR_RXF_WR_LSB      8
`define PCR_TXF_RD_LSB      10
`define PCR_RXF_PIPE_BIT    12
// lane_clock_enable_ctrl fields, one bit each.
`define PCR_EN_NRX_BIT      0
`define PCR_EN_NRXF_BIT     1
`define PCR_EN_NTX_BIT      2
`define PCR_EN_NTXF_BIT     3
`define PCR_EN_WRX_BIT      4
`define PCR_EN_WRXH_BIT     5
`define PCR_EN_WTX_BIT      6
`define PCR_EN_WTXH_BIT     7
// Serializer width and slip fields.
`define PCR_DESER_LSB       0
`define PCR_SER_LSB         3
`define PCR_SLIP_EN_BIT     0
`define PCR_SLIP_SRC_BIT    1

// One-hot coding path patterns.
`define PCR_PATH_NARROW     4'h4
`define PCR_PATH_WIDE       4'h2

// Writable bits of each register; the rest read as zero.
`define PCR_MASK_OCTET_GEAR 32'h0000_0007
`define PCR_MASK_OVERLAY    32'h0000_00FF
`define PCR_MASK_CLK_SRC    32'h0000_1FFF
`define PCR_MASK_CLK_EN     32'h0000_00FF
`define PCR_MASK_SERDES_W   32'h0000_003F
`define PCR_MASK_CDR_SLIP   32'h0000_0003

`define PCR_RST_OCTET_GEAR  32'h0000_0000
`define PCR_RST_OVERLAY     32'h0000_0040
`define PCR_RST_CLK_SRC     32'h0000_00F5
`define PCR_RST_CLK_EN      32'h0000_000F
`define PCR_RST_SERDES_W    32'h0000_003F
`define PCR_RST_CDR_SLIP    32'h0000_0001

`endif

// ### rtl/pcr_pkg.sv
// Purpose: Types shared by the lane coding-rate configuration block.
// Assumes: Constants come from pcr_defines.svh.
// Notes:   State codes are one-hot.
package pcr_pkg;

  typedef enum logic [1:0] {
    PCR_ST_IDLE = 2'b01,
    PCR_ST_ACK  = 2'b10
  } pcr_apb_st_t;

  typedef struct packed {
    pcr_apb_st_t st;
    logic [31:0] octet_gear;
    logic [31:0] overlay;
    logic [31:0] clk_src;
    logic [31:0] clk_en;
    logic [31:0] serdes_w;
    logic [31:0] cdr_slip;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        narrow_mode;
    logic        wide_mode;
  } pcr_cfg_state_t;

  typedef struct packed {
    logic [7:0]  nar_tx_k;
    logic [15:0] nar_tx_disp;
    logic [3:0]  wide_tx_hdr;
    logic        wide_tx_sos;
    logic        wide_tx_elec_idle;
    logic        wide_tx_bypass;
    logic [7:0]  fab_rx_k;
    logic [7:0]  fab_rx_code_viol;
    logic [7:0]  fab_rx_disp_err;
  } pcr_map_state_t;

endpackage

// ### rtl/pcr_map_if.sv
// Purpose: Decoded coding path handed from the register file to the
//          fabric port mapper.
// Assumes: Both flags come from flip-flops; at most one is high.
// Notes:   Neither high means the one-hot field holds no valid path.
`timescale 1ns/10ps
interface pcr_map_if;
  logic narrow_mode;
  logic wide_mode;
  modport cfg (output narrow_mode, output wide_mode);
  modport map (input narrow_mode, input wide_mode);
endinterface

// ### rtl/pcr_path_map.sv
// Purpose: Reinterprets the shared fabric sideband ports for the coding
//          path selected in the overlay register.
// Assumes: Mode flags are registered and change only on an overlay register write or a reset.
// Notes:   One cycle of latency in each direction.
`timescale 1ns/10ps
module pcr_path_map
  import pcr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  pcr_map_if.map           mif,
  input  wire logic [7:0]  fab_tx_k,
  input  wire logic [15:0] fab_tx_dispfnc,
  input  wire logic [7:0]  nar_rx_k,
  input  wire logic [7:0]  nar_rx_code_viol,
  input  wire logic [7:0]  nar_rx_disp_err,
  input  wire logic        wide_rx_bypass,
  input  wire logic [3:0]  wide_rx_hdr,
  input  wire logic        wide_rx_hdr_val,
  input  wire logic        wide_rx_sos,
  input  wire logic        wide_rx_data_val,
  input  wire logic        wide_status_lock,
  input  wire logic        wide_status_hi_ber,
  output pcr_map_state_t   mout
);

  pcr_map_state_t cur_ff;
  pcr_map_state_t nxt_ff;

  always_comb begin
    nxt_ff = '0;
    if (mif.narrow_mode) begin // [R4]
      nxt_ff.nar_tx_k         = fab_tx_k;
      nxt_ff.nar_tx_disp      = fab_tx_dispfnc;
      nxt_ff.fab_rx_k         = nar_rx_k;
      nxt_ff.fab_rx_code_viol = nar_rx_code_viol;
      nxt_ff.fab_rx_disp_err  = nar_rx_disp_err;
    end else if (mif.wide_mode) begin // [R4]
      // Reserved inputs are dropped and reserved outputs held at zero. [R9]
      nxt_ff.wide_tx_hdr        = fab_tx_k[3:0];
      nxt_ff.wide_tx_sos        = fab_tx_k[4];
      nxt_ff.wide_tx_elec_idle  = fab_tx_dispfnc[15];
      nxt_ff.wide_tx_bypass     = fab_tx_dispfnc[14];
      nxt_ff.fab_rx_k[7]        = wide_rx_bypass;
      nxt_ff.fab_rx_disp_err[4] = wide_rx_hdr_val;
      nxt_ff.fab_rx_code_viol[3] = wide_status_hi_ber;
      nxt_ff.fab_rx_disp_err[3] = wide_status_lock;
      nxt_ff.fab_rx_code_viol[2] = wide_rx_sos;
      nxt_ff.fab_rx_disp_err[2] = wide_rx_data_val;
      nxt_ff.fab_rx_code_viol[1] = wide_rx_hdr[3];
      nxt_ff.fab_rx_disp_err[1] = wide_rx_hdr[2];
      nxt_ff.fab_rx_code_viol[0] = wide_rx_hdr[1];
      nxt_ff.fab_rx_disp_err[0] = wide_rx_hdr[0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign mout = cur_ff;

endmodule

// ### verification/pcr_lane_cfg_assertions.sv
// Purpose: Concurrent checks on the ports of the lane coding-rate block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Sideband checks skip the first edge after reset release.
`timescale 1ns/10ps
module pcr_lane_cfg_chk (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  coding_path_onehot_sel,
  input wire logic        narrow_mode,
  input wire logic        wide_mode,
  input wire logic [7:0]  fab_tx_k,
  input wire logic [7:0]  nar_tx_k,
  input wire logic [7:0]  nar_rx_k,
  input wire logic [7:0]  fab_rx_k,
  input wire logic [3:0]  wide_tx_hdr,
  input wire logic        wide_tx_sos,
  input wire logic        wide_rx_bypass
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_ready_wait:
    assert property (psel && penable && !pready |=> pready)
      else $error("pready missing one cycle after access phase");
  a_ready_pulse:
    assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
  a_err_with_ready:
    assert property (pslverr |-> pready)
      else $error("pslverr outside the pready cycle");
  a_err_bad_addr:
    assert property (pready && (paddr > 8'h18 || (pwrite && paddr == 8'h18))
                     |-> pslverr)
      else $error("unmapped or status write not refused");
  a_overlay_write:
    assert property (pready && pwrite && paddr == 8'h04 |->
                     !pslverr && coding_path_onehot_sel == pwdata[7:4])
      else $error("coding path field not taken from write");
  a_mode_decode:
    assert property (narrow_mode == (coding_path_onehot_sel == 4'h4) &&
                     wide_mode == (coding_path_onehot_sel == 4'h2))
      else $error("mode flags disagree with coding path field");
  a_narrow_map:
    assert property ($past(narrow_mode) && $past(rst_n) |->
                     nar_tx_k == $past(fab_tx_k) &&
                     fab_rx_k == $past(nar_rx_k) && wide_tx_hdr == 4'h0)
      else $error("narrow sideband mapping wrong");
  a_wide_map:
    assert property ($past(wide_mode) && $past(rst_n) |->
                     wide_tx_hdr == $past(fab_tx_k[3:0]) &&
                     wide_tx_sos == $past(fab_tx_k[4]) && nar_tx_k == 8'h00 &&
                     fab_rx_k == {$past(wide_rx_bypass), 7'h00})
      else $error("wide sideband mapping wrong");

  c_write: cover property (pready && pwrite && !pslverr);
  c_refused: cover property (pslverr);
  c_wide: cover property (wide_mode);
endmodule

bind pcr_lane_cfg pcr_lane_cfg_chk chk_u (.*);

// ### verification/pcr_ctrl_model.sv
// Purpose: Fabric controller that rewrites the lane fields on a mode change.
// Assumes: One wait state slave; signals change 1 ns after a clock edge.
// Notes:   An idle edge follows every access so psel never toggles twice.
`timescale 1ns/10ps
module pcr_ctrl_model (
  input  wire logic        clock,
  output logic      [7:0]  paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Accesses that never saw pready; the bench counts each as a mismatch.
  int n_timeouts;

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end

  // Call 1 ns after a rising edge; returns 1 ns after a rising edge.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    int n;
    n = 0;
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(posedge clock);
    #1 penable = 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) n_timeouts++;
    q = prdata;
    err = pslverr;
    #1 psel = 1'b0;
    penable = 1'b0;
    @(posedge clock);
    #1;
  endtask

  // Every mode-dependent register is written, never left to power-up state.
  task automatic switch_mode(input logic wide, input logic fab64);
    logic [31:0] w [6];
    logic [31:0] q;
    logic        e;
    w[0] = 32'h0000_0000;
    w[1] = {24'h0, wide ? 4'h2 : 4'h4, 4'h0};
    w[2] = {20'h0, wide ? 4'hA : 4'h0, 8'hF5};
    w[3] = {24'h0, wide ? {fab64, 1'b1, fab64, 1'b1, 4'h0}
                        : 8'h0F};
    w[4] = wide ? 32'h0000_0036 : 32'h0000_003F;
    w[5] = wide ? 32'h0000_0002 : 32'h0000_0001;
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, 8'(4 * i), w[i], q, e);
    end
  endtask
endmodule

// ### verification/tb.sv
// Purpose: Self-checking bench for the lane coding-rate block.
// Assumes: Controller model owns the register port; bench owns sideband.
// Notes:   Modes visited: wide 64-bit, wide 32-bit, narrow, invalid.
`timescale 1ns/10ps
module tb;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        e, octet_swap_sel, rx_fifo_pipe_sel, narrow_mode, wide_mode;
  logic [1:0]  fifo_path_width, fabric_rx_clock_sel, fabric_tx_clock_sel;
  logic [1:0]  coder_rx_clock_sel, coder_tx_clock_sel;
  logic [1:0]  rx_fifo_write_clock_sel, tx_fifo_read_clock_sel;
  logic [3:0]  fabric_path_sel, coding_path_onehot_sel, wide_tx_hdr;
  logic [3:0]  wide_rx_hdr;
  logic        narrow_code_rx_clock_en, narrow_code_rx_fifo_clock_en;
  logic        narrow_code_tx_clock_en, narrow_code_tx_fifo_clock_en;
  logic        wide_code_rx_clock_en, wide_code_rx_half_clock_en;
  logic        wide_code_tx_clock_en, wide_code_tx_half_clock_en;
  logic [2:0]  deser_width_sel, ser_width_sel;
  logic        cdr_slip_enable, cdr_slip_source;
  logic [7:0]  fab_tx_k, fab_rx_k, fab_rx_code_viol, fab_rx_disp_err;
  logic [7:0]  nar_tx_k, nar_rx_k, nar_rx_code_viol, nar_rx_disp_err;
  logic [15:0] fab_tx_dispfnc, nar_tx_disp;
  logic        wide_tx_sos, wide_tx_elec_idle, wide_tx_bypass;
  logic        wide_rx_bypass, wide_rx_hdr_val, wide_rx_sos;
  logic        wide_rx_data_val, wide_status_lock, wide_status_hi_ber;
  int          n_errors, samples_checked, m;
  // Rows: narrow, wide with 64-bit fabric, wide with 32-bit fabric.
  logic [31:0] exp_tab [3][6] = '{
    '{32'h0000_0000, 32'h0000_0040, 32'h0000_00F5, 32'h0000_000F,
      32'h0000_003F, 32'h0000_0001},
    '{32'h0000_0000, 32'h0000_0020, 32'h0000_0AF5, 32'h0000_00F0,
      32'h0000_0036, 32'h0000_0002},
    '{32'h0000_0000, 32'h0000_0020, 32'h0000_0AF5, 32'h0000_0050,
      32'h0000_0036, 32'h0000_0002}};

  pcr_lane_cfg   dut_u (.*);
  pcr_ctrl_model ctl_u (.*);

  always #4 clock = ~clock;

  task automatic conclude();
    n_errors += ctl_u.n_timeouts;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] x,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, x, g);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    ctl_u.xfer(1'b0, a, 32'h0, q, e);
    chk("read data", x, q);
    chk("read error flag", 32'h0, 32'(e));
  endtask

  task automatic fields(input int r);
    chk("gear fields", exp_tab[r][0],
        32'({fifo_path_width, octet_swap_sel}));
    chk("overlay fields", exp_tab[r][1],
        32'({coding_path_onehot_sel, fabric_path_sel}));
    chk("clock selects", exp_tab[r][2],
        32'({rx_fifo_pipe_sel, tx_fifo_read_clock_sel,
        rx_fifo_write_clock_sel, coder_tx_clock_sel, coder_rx_clock_sel,
        fabric_tx_clock_sel, fabric_rx_clock_sel}));
    chk("clock enables", exp_tab[r][3], 32'({wide_code_tx_half_clock_en,
        wide_code_tx_clock_en, wide_code_rx_half_clock_en,
        wide_code_rx_clock_en, narrow_code_tx_fifo_clock_en,
        narrow_code_tx_clock_en, narrow_code_rx_fifo_clock_en,
        narrow_code_rx_clock_en}));
    chk("width selects", exp_tab[r][4],
        32'({ser_width_sel, deser_width_sel}));
    chk("slip fields", exp_tab[r][5],
        32'({cdr_slip_source, cdr_slip_enable}));
  endtask

  // Mode 0 narrow, 1 wide, 2 no valid path.
  task automatic sideband(input int md);
    fab_tx_k = 8'h1A;
    fab_tx_dispfnc = 16'hC3A5;
    {nar_rx_k, nar_rx_code_viol, nar_rx_disp_err} = 24'h5C_9669;
    {wide_rx_bypass, wide_rx_hdr, wide_rx_hdr_val, wide_rx_sos} = 7'h6E;
    {wide_rx_data_val, wide_status_lock, wide_status_hi_ber} = 3'h5;
    @(posedge clock);
    #1;
    chk("tx sideband", md == 0 ? 32'h0D61_D280 : md == 1 ? 32'h57 : 32'h0,
        32'({nar_tx_k, nar_tx_disp, wide_tx_hdr, wide_tx_sos,
             wide_tx_elec_idle, wide_tx_bypass}));
    chk("rx sideband", md == 0 ? 32'h5C_9669 : md == 1 ? 32'h80_0B15 : 32'h0,
        32'({fab_rx_k, fab_rx_code_viol, fab_rx_disp_err}));
  endtask

  initial begin
    {clock, rst_n, fab_tx_k, fab_tx_dispfnc, nar_rx_k} = '0;
    {nar_rx_code_viol, nar_rx_disp_err, wide_rx_bypass, wide_rx_hdr} = '0;
    {wide_rx_hdr_val, wide_rx_sos, wide_rx_data_val} = '0;
    {wide_status_lock, wide_status_hi_ber} = '0;
    repeat (5) @(posedge clock);
    #1 rst_n = 1'b1;
    @(posedge clock);
    #1;
    fields(0);
    for (int i = 0; i < 6; i++) rd(8'(4 * i), exp_tab[0][i]);
    $display("test reset_values done");
    for (int k = 0; k < 3; k++) begin
      m = (k + 1) % 3;
      ctl_u.switch_mode(m != 0, m == 1);
      fields(m);
      for (int i = 0; i < 6; i++) rd(8'(4 * i), exp_tab[m][i]);
      rd(8'h18, {30'h0, m != 0, m == 0});
      sideband(m == 0 ? 0 : 1);
      $display("test mode_%0d done", m);
    end
    ctl_u.xfer(1'b0, 8'h1C, 32'h0, q, e);
    chk("unmapped error", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, q);
    ctl_u.xfer(1'b1, 8'h18, 32'hFFFF_FFFF, q, e);
    chk("status write error", 32'h1, 32'(e));
    rd(8'h18, 32'h0000_0001);
    ctl_u.xfer(1'b1, 8'h04, 32'hFFFF_FF0F, q, e);
    chk("overlay write error", 32'h0, 32'(e));
    rd(8'h04, 32'h0000_000F);
    chk("mode flags", 32'h0, 32'({wide_mode, narrow_mode}));
    sideband(2);
    ctl_u.xfer(1'b1, 8'h00, 32'hFFFF_FFFF, q, e);
    ctl_u.xfer(1'b1, 8'h08, 32'hFFFF_FFFF, q, e);
    chk("gear fields", 32'h7,
        32'({fifo_path_width, octet_swap_sel}));
    chk("pipe select", 32'h1, 32'(rx_fifo_pipe_sel));
    rd(8'h08, 32'h0000_1FFF);
    // A reset in mid-run must bring back every narrow-mode setting.
    rst_n = 1'b0;
    @(posedge clock);
    #1 rst_n = 1'b1;
    @(posedge clock);
    #1;
    fields(0);
    rd(8'h18, 32'h0000_0001);
    ctl_u.switch_mode(1'b0, 1'b0);
    fields(0);
    $display("test refusals done");
    conclude();
  end

  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    conclude();
  end
endmodule
